// *** logic/nstr_pkg.sv ***
// How it works
// RL1 - Nibble swap exchanges low and high nibbles of the file byte, result to destination.
// RL2 - Nibble swap: decode Q1, read Q2, process Q3, write destination Q4; one cycle.
// RL3 - Table read loads the program byte addressed by the pointer into the latch.
// RL4 - Table pointer is 21 bits, byte granular, covering two megabytes.
// RL5 - Pointer bit 0 low gives the low byte, high gives the high byte.
// RL6 - Opcode 0000 0000 0000 10mm; mode none, post-inc, post-dec, pre-inc.
// RL7 - Table read is one word, two cycles: decode, then memory read and latch write.
// RL8 - Destination bit 0 writes the working register, 1 writes the file register.
// RL9 - Access bit 0 uses the access bank, 1 uses the bank select register.
// RL10 - Access bit 0 with extended set on and address up to 5Fh is indexed.
// RL11 - Neither instruction changes any arithmetic status flag.
package nstr_pkg;

    // ==========================================================================
    // Widths and opcodes.
    localparam int PTR_W = 21;
    localparam int DM_AW = 12;
    localparam logic [5:0] SWAP_OPC = 6'h0E;
    localparam logic [13:0] TRD_OPC = 14'h0002;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC = 2'h3;
    localparam logic DEST_WREG = 1'h0;

    // ==========================================================================
    // File address mapping.
    localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // ==========================================================================
    // Quarter phases.
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    // ==========================================================================
    // Register offsets and reset values.
    localparam logic [3:0] REG_PTR_LOW = 4'h0;
    localparam logic [3:0] REG_PTR_HIGH = 4'h1;
    localparam logic [3:0] REG_PTR_UPPER = 4'h2;
    localparam logic [3:0] REG_LATCH = 4'h3;
    localparam logic [3:0] REG_WREG = 4'h4;
    localparam logic [3:0] REG_BANK = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    localparam logic [3:0] REG_CONFIG = 4'h7;
    localparam logic [3:0] REG_STATE = 4'h8;
    localparam logic [20:0] PTR_RST = 21'h000000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] STATUS_RST = 5'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_SWAP, ST_TRD1, ST_TRD2} nstr_state_e;

endpackage

// *** logic/nstr_phase_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface nstr_phase_if;
    logic [1:0] quarter;
    logic step;
    modport src (output quarter, output step);
    modport dst (input quarter, input step);
endinterface
`default_nettype wire

// *** logic/nstr_qphase.sv ***
`timescale 1ns/1ps
`default_nettype none
module nstr_qphase #(
    parameter int DIV = 1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Phase out.
    nstr_phase_if.src ph
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic [1:0] quarter_ff;
    logic [1:0] nxt_quarter;
    logic step;

    // ==========================================================================
    // Divider: one step pulse ends every quarter.
    always_comb begin
        step = (cnt_ff == LAST);
        nxt_cnt = step ? '0 : cnt_ff + CW'(1);
        nxt_quarter = step ? quarter_ff + 2'h1 : quarter_ff;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= '0;
            quarter_ff <= nstr_pkg::Q1;
        end else begin
            cnt_ff <= nxt_cnt;
            quarter_ff <= nxt_quarter;
        end
    end

    assign ph.quarter = quarter_ff;
    assign ph.step = step;
endmodule
`default_nettype wire

// *** logic/nstr_core.sv ***
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nstr_core #(
    parameter int QUARTER_DIV = 1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Instruction stream.
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic busy,
    output logic [1:0] quarter,
    // Data memory.
    input wire logic [11:0] index_base,
    output logic [11:0] dm_addr,
    output logic dm_rd,
    input wire logic [7:0] dm_rdata,
    output logic dm_we,
    output logic [7:0] dm_wdata,
    // Program memory.
    output logic [19:0] pm_addr,
    output logic pm_rd,
    input wire logic [15:0] pm_rdata,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    nstr_phase_if ph ();

    nstr_qphase #(.DIV(QUARTER_DIV)) u_qphase (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ph(ph.src)
    );

    nstr_pkg::nstr_state_e state_ff;
    nstr_pkg::nstr_state_e nxt_state;
    logic [20:0] table_pointer_ff;
    logic [20:0] nxt_pointer;
    logic [7:0] table_latch_ff;
    logic [7:0] nxt_latch;
    logic [7:0] wreg_ff;
    logic [7:0] nxt_wreg;
    logic [3:0] bank_select_register_ff;
    logic [3:0] nxt_bank;
    logic [4:0] status_ff;
    logic [4:0] nxt_status;
    logic extended_set_enable_ff;
    logic nxt_ext;
    logic [11:0] dm_addr_ff;
    logic [11:0] nxt_dm_addr;
    logic dest_ff;
    logic nxt_dest;
    logic [1:0] pointer_update_field_ff;
    logic [1:0] nxt_mode;
    logic [7:0] operand_ff;
    logic [7:0] nxt_operand;
    logic [7:0] result_ff;
    logic [7:0] nxt_result;
    logic [7:0] byte_ff;
    logic [7:0] nxt_byte;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic take;
    logic is_swap;
    logic is_trd;
    logic at_q2;
    logic at_q3;
    logic at_q4;

    // ==========================================================================
    // File address mapping.
    function automatic logic [11:0] map_addr(input logic [7:0] f, input logic a,
                                             input logic [3:0] bank, input logic xen,
                                             input logic [11:0] base);
        logic [11:0] m;
        if (a) begin
            m = {bank, f}; // RL9
        end else if (xen && (f <= nstr_pkg::LIT_OFFSET_MAX)) begin
            m = base + {4'h0, f}; // RL10
        end else if (f < nstr_pkg::ACCESS_SPLIT) begin
            m = {4'h0, f}; // RL9
        end else begin
            m = {nstr_pkg::ACCESS_HIGH_BANK, f};
        end
        return m;
    endfunction

    // ==========================================================================
    // Decode and sequencing.
    always_comb begin
        take = (state_ff == nstr_pkg::ST_IDLE) && (ph.quarter == nstr_pkg::Q1) && ph.step;
        is_swap = (instr[15:10] == nstr_pkg::SWAP_OPC);
        is_trd = (instr[15:2] == nstr_pkg::TRD_OPC); // RL6
        at_q2 = ph.step && (ph.quarter == nstr_pkg::Q2);
        at_q3 = ph.step && (ph.quarter == nstr_pkg::Q3);
        at_q4 = ph.step && (ph.quarter == nstr_pkg::Q4);
        nxt_state = state_ff;
        nxt_dm_addr = dm_addr_ff;
        nxt_dest = dest_ff;
        nxt_mode = pointer_update_field_ff;
        nxt_operand = operand_ff;
        nxt_result = result_ff;
        nxt_byte = byte_ff;
        unique case (state_ff)
            nstr_pkg::ST_IDLE: begin
                if (take && instr_valid && is_swap) begin
                    nxt_state = nstr_pkg::ST_SWAP;
                    nxt_dest = instr[9];
                    nxt_dm_addr = map_addr(instr[7:0], instr[8], bank_select_register_ff,
                                           extended_set_enable_ff, index_base);
                end else if (take && instr_valid && is_trd) begin
                    nxt_state = nstr_pkg::ST_TRD1;
                    nxt_mode = instr[1:0];
                end
            end
            nstr_pkg::ST_SWAP: begin
                if (at_q2) begin
                    nxt_operand = dm_rdata; // RL2
                end
                if (at_q3) begin
                    nxt_result = {operand_ff[3:0], operand_ff[7:4]}; // RL1
                end
                if (at_q4) begin
                    nxt_state = nstr_pkg::ST_IDLE; // RL2
                end
            end
            nstr_pkg::ST_TRD1: begin
                if (at_q4) begin
                    nxt_state = nstr_pkg::ST_TRD2; // RL7
                end
            end
            nstr_pkg::ST_TRD2: begin
                if (at_q3) begin
                    nxt_byte = table_pointer_ff[0] ? pm_rdata[15:8] : pm_rdata[7:0]; // RL5
                end
                if (at_q4) begin
                    nxt_state = nstr_pkg::ST_IDLE; // RL7
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= nstr_pkg::ST_IDLE;
            dm_addr_ff <= '0;
            dest_ff <= 1'h1;
            pointer_update_field_ff <= nstr_pkg::MODE_NONE;
            operand_ff <= nstr_pkg::BYTE_RST;
            result_ff <= nstr_pkg::BYTE_RST;
            byte_ff <= nstr_pkg::BYTE_RST;
        end else begin
            state_ff <= nxt_state;
            dm_addr_ff <= nxt_dm_addr;
            dest_ff <= nxt_dest;
            pointer_update_field_ff <= nxt_mode;
            operand_ff <= nxt_operand;
            result_ff <= nxt_result;
            byte_ff <= nxt_byte;
        end
    end

    // ==========================================================================
    // Architectural registers; hardware updates win over a software write.
    always_comb begin
        nxt_pointer = table_pointer_ff;
        nxt_latch = table_latch_ff;
        nxt_wreg = wreg_ff;
        nxt_bank = bank_select_register_ff;
        nxt_status = status_ff;
        nxt_ext = extended_set_enable_ff;
        if (reg_wr) begin
            unique case (reg_addr)
                nstr_pkg::REG_PTR_LOW: nxt_pointer[7:0] = reg_wdata;
                nstr_pkg::REG_PTR_HIGH: nxt_pointer[15:8] = reg_wdata;
                nstr_pkg::REG_PTR_UPPER: nxt_pointer[20:16] = reg_wdata[4:0]; // RL4
                nstr_pkg::REG_LATCH: nxt_latch = reg_wdata;
                nstr_pkg::REG_WREG: nxt_wreg = reg_wdata;
                nstr_pkg::REG_BANK: nxt_bank = reg_wdata[3:0];
                nstr_pkg::REG_STATUS: nxt_status = reg_wdata[4:0];
                nstr_pkg::REG_CONFIG: nxt_ext = reg_wdata[0];
                default: nxt_pointer = table_pointer_ff;
            endcase
        end
        if ((state_ff == nstr_pkg::ST_SWAP) && at_q4 && (dest_ff == nstr_pkg::DEST_WREG)) begin
            nxt_wreg = result_ff; // RL8
        end
        if ((state_ff == nstr_pkg::ST_TRD1) && at_q4 &&
            (pointer_update_field_ff == nstr_pkg::MODE_PRE_INC)) begin
            nxt_pointer = table_pointer_ff + 21'h1; // RL6
        end
        if ((state_ff == nstr_pkg::ST_TRD2) && at_q4) begin
            nxt_latch = byte_ff; // RL3
            if (pointer_update_field_ff == nstr_pkg::MODE_POST_INC) begin
                nxt_pointer = table_pointer_ff + 21'h1; // RL6
            end else if (pointer_update_field_ff == nstr_pkg::MODE_POST_DEC) begin
                nxt_pointer = table_pointer_ff - 21'h1; // RL6
            end
        end
    end

    // Status flags are never touched by either instruction, only by software.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            table_pointer_ff <= nstr_pkg::PTR_RST;
            table_latch_ff <= nstr_pkg::BYTE_RST;
            wreg_ff <= nstr_pkg::BYTE_RST;
            bank_select_register_ff <= nstr_pkg::BANK_RST;
            status_ff <= nstr_pkg::STATUS_RST; // RL11
            extended_set_enable_ff <= 1'h0;
        end else begin
            table_pointer_ff <= nxt_pointer;
            table_latch_ff <= nxt_latch;
            wreg_ff <= nxt_wreg;
            bank_select_register_ff <= nxt_bank;
            status_ff <= nxt_status;
            extended_set_enable_ff <= nxt_ext;
        end
    end

    // ==========================================================================
    // Register read port; unmapped offsets read as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                nstr_pkg::REG_PTR_LOW: nxt_rdata = table_pointer_ff[7:0];
                nstr_pkg::REG_PTR_HIGH: nxt_rdata = table_pointer_ff[15:8];
                nstr_pkg::REG_PTR_UPPER: nxt_rdata = {3'h0, table_pointer_ff[20:16]};
                nstr_pkg::REG_LATCH: nxt_rdata = table_latch_ff;
                nstr_pkg::REG_WREG: nxt_rdata = wreg_ff;
                nstr_pkg::REG_BANK: nxt_rdata = {4'h0, bank_select_register_ff};
                nstr_pkg::REG_STATUS: nxt_rdata = {3'h0, status_ff};
                nstr_pkg::REG_CONFIG: nxt_rdata = {7'h00, extended_set_enable_ff};
                nstr_pkg::REG_STATE: nxt_rdata = {3'h0, state_ff, ph.quarter, busy};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================================
    // Outputs. Memories must answer within the quarter that strobes them.
    assign instr_ready = take;
    assign busy = (state_ff != nstr_pkg::ST_IDLE);
    assign quarter = ph.quarter;
    assign dm_addr = dm_addr_ff;
    assign dm_rd = (state_ff == nstr_pkg::ST_SWAP) && (ph.quarter == nstr_pkg::Q2); // RL2
    assign dm_we = (state_ff == nstr_pkg::ST_SWAP) && at_q4 && dest_ff; // RL8
    assign dm_wdata = result_ff;
    assign pm_addr = table_pointer_ff[20:1]; // RL4
    assign pm_rd = (state_ff == nstr_pkg::ST_TRD2) && (ph.quarter == nstr_pkg::Q3); // RL7
    assign reg_rdata = rdata_ff;

    // ==========================================================================
    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_swap_q3;
        (state_ff == nstr_pkg::ST_SWAP) && at_q3;
    endsequence
    sequence s_trd2_q4;
        (state_ff == nstr_pkg::ST_TRD2) && at_q4;
    endsequence

    property p_swap_nibbles;
        s_swap_q3 |=> result_ff == {$past(operand_ff[3:0]), $past(operand_ff[7:4])};
    endproperty
    a_swap_nibbles: assert property (p_swap_nibbles) else $error("swap result wrong"); // RL1

    property p_swap_end;
        (state_ff == nstr_pkg::ST_SWAP) && at_q4 |=> state_ff == nstr_pkg::ST_IDLE;
    endproperty
    a_swap_end: assert property (p_swap_end) else $error("swap not one cycle"); // RL2

    property p_latch_load;
        s_trd2_q4 |=> table_latch_ff == $past(byte_ff);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded"); // RL3

    property p_byte_pick;
        (state_ff == nstr_pkg::ST_TRD2) && at_q3 |=>
            byte_ff == ($past(table_pointer_ff[0]) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0]));
    endproperty
    a_byte_pick: assert property (p_byte_pick) else $error("wrong byte half"); // RL5

    property p_post_dec;
        (s_trd2_q4 and (pointer_update_field_ff == nstr_pkg::MODE_POST_DEC)) |=>
            table_pointer_ff == $past(table_pointer_ff) - 21'h1;
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post decrement wrong"); // RL6

    property p_pre_inc;
        (state_ff == nstr_pkg::ST_TRD1) && at_q4 &&
        (pointer_update_field_ff == nstr_pkg::MODE_PRE_INC) |=>
            table_pointer_ff == $past(table_pointer_ff) + 21'h1;
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre increment wrong"); // RL6

    property p_trd_two;
        (state_ff == nstr_pkg::ST_TRD1) && at_q4 |=> state_ff == nstr_pkg::ST_TRD2;
    endproperty
    a_trd_two: assert property (p_trd_two) else $error("table read not two cycles"); // RL7

    property p_dest;
        dm_we |-> dest_ff && (ph.quarter == nstr_pkg::Q4) && (dm_wdata == result_ff);
    endproperty
    a_dest: assert property (p_dest) else $error("file write misplaced"); // RL8

    property p_bank;
        take && instr_valid && is_swap && instr[8] |=>
            dm_addr_ff == {$past(bank_select_register_ff), $past(instr[7:0])};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong"); // RL9

    property p_indexed;
        take && instr_valid && is_swap && !instr[8] && extended_set_enable_ff &&
        (instr[7:0] <= nstr_pkg::LIT_OFFSET_MAX) |=>
            dm_addr_ff == $past(index_base) + {4'h0, $past(instr[7:0])};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // RL10

    property p_flags;
        busy && !reg_wr |=> $stable(status_ff);
    endproperty
    a_flags: assert property (p_flags) else $error("status changed"); // RL11
endmodule
`default_nettype wire

// *** logic/unused_placeholder_none.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ==========================================================================
    // Clock, reset and design ports.
    logic clk_sys;
    logic sys_rst;
    logic [15:0] instr;
    logic instr_valid;
    logic instr_ready;
    logic busy;
    logic [1:0] quarter;
    logic [11:0] index_base;
    logic [11:0] dm_addr;
    logic dm_rd;
    logic [7:0] dm_rdata;
    logic dm_we;
    logic [7:0] dm_wdata;
    logic [19:0] pm_addr;
    logic pm_rd;
    logic [15:0] pm_rdata;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    int num_errors;
    int n_checks;
    logic [11:0] got_addr;
    logic got_we;
    logic [7:0] got_wdata;
    logic [19:0] got_paddr;
    int busy_n;
    logic [7:0] rd;
    logic [20:0] ptr;

    nstr_core #(.QUARTER_DIV(1)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .busy(busy), .quarter(quarter), .index_base(index_base),
        .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_rdata(dm_rdata), .dm_we(dm_we),
        .dm_wdata(dm_wdata), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ==========================================================================
    // Checking and closing.
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_up(input string what);
        num_errors++;
        $display("MISMATCH %s expected completion seen timeout", what);
        report_and_stop();
    endtask

    // ==========================================================================
    // Register port access.
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic ptr_write(input logic [20:0] p);
        reg_write(nstr_pkg::REG_PTR_LOW, p[7:0]);
        reg_write(nstr_pkg::REG_PTR_HIGH, p[15:8]);
        reg_write(nstr_pkg::REG_PTR_UPPER, {3'h0, p[20:16]});
    endtask

    task automatic ptr_read(output logic [20:0] p);
        logic [7:0] b;
        reg_read(nstr_pkg::REG_PTR_LOW, b);
        p[7:0] = b;
        reg_read(nstr_pkg::REG_PTR_HIGH, b);
        p[15:8] = b;
        reg_read(nstr_pkg::REG_PTR_UPPER, b);
        p[20:16] = b[4:0];
    endtask

    // ==========================================================================
    // Instruction issue; memory answers are held steady for the whole run of it.
    task automatic exec(input logic [15:0] w, input logic [7:0] mrd, input logic [15:0] prd);
        int n;
        @(posedge clk_sys);
        instr <= w;
        instr_valid <= 1'b1;
        dm_rdata <= mrd;
        pm_rdata <= prd;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (instr_ready !== 1'b1 && n < 50);
        if (n >= 50) give_up("instr_ready");
        check("quarter at decode", quarter, nstr_pkg::Q1);
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        got_we = 1'b0;
        busy_n = 0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (busy === 1'b1) busy_n++;
            if (dm_rd === 1'b1) got_addr = dm_addr;
            if (dm_we === 1'b1) begin
                got_we = 1'b1;
                got_wdata = dm_wdata;
            end
            if (pm_rd === 1'b1) got_paddr = pm_addr;
        end while (busy === 1'b1 && n < 40);
        if (n >= 40) give_up("busy");
    endtask

    // Access bit 0, so the file address mapping depends on the extended set switch.
    task automatic swap_map(input logic [7:0] f, input logic xen, input logic [11:0] exp);
        reg_write(nstr_pkg::REG_CONFIG, {7'h00, xen});
        exec({nstr_pkg::SWAP_OPC, 1'b1, 1'b0, f}, 8'hC3, 16'h0000);
        check("dm_addr mapped", got_addr, exp);
        check("dm_wdata mapped", got_wdata, 8'h3C);
    endtask

    task automatic trd(input logic [1:0] m, input logic [20:0] p, input logic [15:0] prd,
                       input logic [19:0] pa, input logic [7:0] lat, input logic [20:0] pe);
        ptr_write(p);
        exec({nstr_pkg::TRD_OPC, m}, 8'h00, prd);
        check("trd busy cycles", busy_n, 7);
        check("pm_addr", got_paddr, pa);
        reg_read(nstr_pkg::REG_LATCH, rd);
        check("table_latch", rd, lat);
        ptr_read(ptr);
        check("table_pointer", ptr, pe);
    endtask

    // ==========================================================================
    // Main sequence.
    initial begin
        num_errors = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        instr = 16'h0000;
        instr_valid = 1'b0;
        index_base = 12'h400;
        dm_rdata = 8'h00;
        pm_rdata = 16'h0000;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        got_addr = 12'h000;
        got_wdata = 8'h00;
        got_paddr = 20'h00000;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;

        for (int i = 0; i < 8; i++) begin
            reg_read(i[3:0], rd);
            check("reset value", rd, 8'h00);
        end
        reg_write(4'hB, 8'hA5);
        reg_read(4'hB, rd);
        check("unmapped offset", rd, 8'h00);
        $display("Test registers done");

        // Status set by software must survive every instruction below.
        reg_write(nstr_pkg::REG_STATUS, 8'h15);
        reg_write(nstr_pkg::REG_BANK, 8'h03);
        exec({nstr_pkg::SWAP_OPC, 1'b1, 1'b1, 8'h12}, 8'h53, 16'h0000);
        check("swap busy cycles", busy_n, 3);
        check("dm_addr banked", got_addr, 12'h312);
        check("dm_we seen", got_we, 1'b1);
        check("dm_wdata", got_wdata, 8'h35);
        reg_read(nstr_pkg::REG_WREG, rd);
        check("W untouched", rd, 8'h00);
        exec({nstr_pkg::SWAP_OPC, nstr_pkg::DEST_WREG, 1'b0, 8'h90}, 8'hA7, 16'h0000);
        check("dm_we absent", got_we, 1'b0);
        check("dm_addr access high", got_addr, 12'hF90);
        reg_read(nstr_pkg::REG_WREG, rd);
        check("W swapped", rd, 8'h7A);
        swap_map(8'h5F, 1'b0, 12'h05F);
        swap_map(8'h5F, 1'b1, 12'h45F);
        swap_map(8'h60, 1'b1, 12'h060);
        swap_map(8'h00, 1'b1, 12'h400);
        $display("Test nibble swap done");

        trd(nstr_pkg::MODE_NONE, 21'h1FFFFF, 16'hAB12, 20'hFFFFF, 8'hAB, 21'h1FFFFF);
        trd(nstr_pkg::MODE_POST_INC, 21'h00A356, 16'h7734, 20'h051AB, 8'h34, 21'h00A357);
        trd(nstr_pkg::MODE_POST_DEC, 21'h000000, 16'h9C5E, 20'h00000, 8'h5E, 21'h1FFFFF);
        trd(nstr_pkg::MODE_PRE_INC, 21'h01A357, 16'h1234, 20'h0D1AC, 8'h34, 21'h01A358);
        trd(nstr_pkg::MODE_PRE_INC, 21'h1FFFFF, 16'h6655, 20'h00000, 8'h55, 21'h000000);
        $display("Test table read done");

        reg_read(nstr_pkg::REG_STATUS, rd);
        check("status kept", rd, 8'h15);
        $display("Test status done");
        report_and_stop();
    end
endmodule
`default_nettype wire
